// file: src/dsp_pkg.sv
// package: constants and types for the dual-slope pwm timer
package dsp_pkg;
   // register offsets (word index on the plain register port)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_CMP_A  = 4'h1;
   localparam logic [3:0] ADDR_CMP_B  = 4'h2;
   localparam logic [3:0] ADDR_CAP    = 4'h3;
   localparam logic [3:0] ADDR_CNT    = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   localparam logic [3:0] ADDR_MASK   = 4'h6;
   localparam logic [3:0] ADDR_PRESC  = 4'h7;

   // control register field positions
   localparam int CTRL_WGM_LSB   = 0;
   localparam int CTRL_COMA_LSB  = 4;
   localparam int CTRL_COMB_LSB  = 6;
   localparam int CTRL_DIRA_BIT  = 8;
   localparam int CTRL_DIRB_BIT  = 9;

   // status bit positions and status width
   localparam int ST_OVF = 0;
   localparam int ST_CMA = 1;
   localparam int ST_CMB = 2;
   localparam int ST_CAP = 3;
   localparam int ST_W   = 4;

   // waveform mode encodings
   localparam logic [3:0] WGM_PC8   = 4'h1;
   localparam logic [3:0] WGM_PC9   = 4'h2;
   localparam logic [3:0] WGM_PC10  = 4'h3;
   localparam logic [3:0] WGM_PFC_C = 4'h8;
   localparam logic [3:0] WGM_PFC_A = 4'h9;
   localparam logic [3:0] WGM_PC_C  = 4'ha;
   localparam logic [3:0] WGM_PC_A  = 4'hb;

   // fixed top values and the bottom value
   localparam logic [15:0] TOP_8  = 16'h00ff;
   localparam logic [15:0] TOP_9  = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;
   localparam logic [15:0] BOTTOM = 16'h0000;

   // output mode encodings
   localparam logic [1:0] COM_NONINV = 2'h2;
   localparam logic [1:0] COM_INV    = 2'h3;

   localparam logic [15:0] RESET_VAL = 16'h0000;

   typedef enum logic [0:0] {
      DIR_UP   = 1'b0,
      DIR_DOWN = 1'b1
   } dsp_dir_e;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } dsp_req_s;

   typedef struct packed {
      logic [1:0] value;
      logic [1:0] enable;
   } dsp_pins_s;
endpackage

// file: src/dsp_timer.sv
// dual-slope 16-bit pwm timer with register port and interrupt
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dsp_timer (
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire dsp_pkg::dsp_req_s req,
   output logic [15:0]          rdata,
   output var dsp_pkg::dsp_pins_s pins,
   output logic                 irq
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [9:0]          ctrl_reg;
   logic [15:0]         buf_a_reg;
   logic [15:0]         buf_b_reg;
   logic [15:0]         cmp_a_reg;
   logic [15:0]         cmp_b_reg;
   logic [15:0]         cap_reg;
   logic [15:0]         cnt_reg;
   logic [15:0]         presc_reg;
   logic [15:0]         div_reg;
   logic [3:0]          status_reg;
   logic [3:0]          mask_reg;
   logic [1:0]          oc_reg;
   dsp_pkg::dsp_dir_e   dir_reg;

   logic [3:0]          wgm;
   logic [1:0]          com_a;
   logic [1:0]          com_b;
   logic                tick;
   logic                pc_mode;
   logic                pfc_mode;
   logic                active;
   logic [15:0]         top;
   logic                at_top;
   logic                at_bottom;
   logic                top_is_a;
   logic                load_at_top;
   logic                load_at_bottom;
   logic [15:0]         fix_mask;
   logic [3:0]          ev;
   logic [1:0]          match;
   logic                oc_down;

   assign wgm   = ctrl_reg[dsp_pkg::CTRL_WGM_LSB +: 4];
   assign com_a = ctrl_reg[dsp_pkg::CTRL_COMA_LSB +: 2];
   assign com_b = ctrl_reg[dsp_pkg::CTRL_COMB_LSB +: 2];

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   // phase correct mode set
   assign pc_mode  = (wgm == dsp_pkg::WGM_PC8) || (wgm == dsp_pkg::WGM_PC9) ||
                     (wgm == dsp_pkg::WGM_PC10) || (wgm == dsp_pkg::WGM_PC_C) ||
                     (wgm == dsp_pkg::WGM_PC_A);
   assign pfc_mode = (wgm == dsp_pkg::WGM_PFC_C) || (wgm == dsp_pkg::WGM_PFC_A);
   assign active   = pc_mode || pfc_mode;
   assign top_is_a = (wgm == dsp_pkg::WGM_PC_A) || (wgm == dsp_pkg::WGM_PFC_A);

   always_comb begin
      case (wgm)
         dsp_pkg::WGM_PC8:   top = dsp_pkg::TOP_8;
         dsp_pkg::WGM_PC9:   top = dsp_pkg::TOP_9;
         dsp_pkg::WGM_PC10:  top = dsp_pkg::TOP_10;
         dsp_pkg::WGM_PC_C:  top = cap_reg;
         dsp_pkg::WGM_PFC_C: top = cap_reg;
         dsp_pkg::WGM_PC_A:  top = cmp_a_reg;
         dsp_pkg::WGM_PFC_A: top = cmp_a_reg;
         default:            top = dsp_pkg::TOP_8;
      endcase
   end

   always_comb begin
      case (wgm)
         dsp_pkg::WGM_PC8:  fix_mask = dsp_pkg::TOP_8;
         dsp_pkg::WGM_PC9:  fix_mask = dsp_pkg::TOP_9;
         dsp_pkg::WGM_PC10: fix_mask = dsp_pkg::TOP_10;
         default:           fix_mask = 16'hffff;
      endcase
   end

   assign at_top         = (cnt_reg == top);
   assign at_bottom      = (cnt_reg == dsp_pkg::BOTTOM);
   assign load_at_top    = tick && pc_mode && at_top;
   assign load_at_bottom = tick && pfc_mode && at_bottom;

   // ------------------------------------------------------------
   // timer clock enable divider
   // ------------------------------------------------------------
   // presc_reg holds divide-minus-one; zero ticks every clock
   always_ff @(posedge clock) begin
      if (rst || div_reg >= presc_reg) begin
         div_reg <= dsp_pkg::RESET_VAL;
      end else begin
         div_reg <= div_reg + 16'h0001;
      end
   end
   assign tick = active && (div_reg >= presc_reg);

   // ------------------------------------------------------------
   // counter and direction
   // ------------------------------------------------------------
   // counter resets to zero, counting up
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_reg <= dsp_pkg::RESET_VAL;
         dir_reg <= dsp_pkg::DIR_UP;
      end else if (req.wr && req.addr == dsp_pkg::ADDR_CNT) begin
         cnt_reg <= req.wdata;
      end else if (tick) begin
         // top lasts one tick, then reverse
         if (dir_reg == dsp_pkg::DIR_UP) begin
            if (at_top) begin
               dir_reg <= dsp_pkg::DIR_DOWN;
               cnt_reg <= cnt_reg - 16'h0001;
            end else begin
               cnt_reg <= cnt_reg + 16'h0001;
            end
         end else begin
            if (at_bottom) begin
               dir_reg <= dsp_pkg::DIR_UP;
               cnt_reg <= cnt_reg + 16'h0001;
            end else begin
               cnt_reg <= cnt_reg - 16'h0001;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // compare buffers and active compare values
   // ------------------------------------------------------------
   // writes land in the buffer; the active copy follows it at the update point.
   // outside dual-slope modes the buffer passes straight through.
   always_ff @(posedge clock) begin
      if (rst) begin
         buf_a_reg <= dsp_pkg::RESET_VAL;
         buf_b_reg <= dsp_pkg::RESET_VAL;
         cap_reg   <= dsp_pkg::RESET_VAL;
      end else if (req.wr) begin
         if (req.addr == dsp_pkg::ADDR_CMP_A) begin
            buf_a_reg <= req.wdata & fix_mask;
         end
         if (req.addr == dsp_pkg::ADDR_CMP_B) begin
            buf_b_reg <= req.wdata & fix_mask;
         end
         // capture top is not double buffered
         if (req.addr == dsp_pkg::ADDR_CAP) begin
            cap_reg <= req.wdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         cmp_a_reg <= dsp_pkg::RESET_VAL;
         cmp_b_reg <= dsp_pkg::RESET_VAL;
      end else if (!active || load_at_top || load_at_bottom) begin
         cmp_a_reg <= buf_a_reg;
         cmp_b_reg <= buf_b_reg;
      end
   end

   // ------------------------------------------------------------
   // compare outputs
   // ------------------------------------------------------------
   // equality match per channel
   assign match[0] = tick && (cnt_reg == cmp_a_reg);
   assign match[1] = tick && (cnt_reg == cmp_b_reg);

   function automatic logic next_oc(input logic [1:0] com, input logic m,
                                    input logic down, input logic cur);
      logic inv;
      inv = (com == dsp_pkg::COM_INV);
      if (m && (com == dsp_pkg::COM_NONINV || inv)) begin
         // up clears, down sets, inverted flips
         next_oc = down ^ inv;
      end else begin
         next_oc = cur;
      end
   endfunction

   // bottom match on turn keeps level low; top match sets high
   // the bottom tick arrives with the direction still down, so it is forced to count as up
   assign oc_down = (dir_reg == dsp_pkg::DIR_DOWN && !at_bottom) || at_top;

   always_ff @(posedge clock) begin
      if (rst) begin
         oc_reg <= 2'h0;
      end else begin
         oc_reg[0] <= next_oc(com_a, match[0], oc_down, oc_reg[0]);
         oc_reg[1] <= next_oc(com_b, match[1], oc_down, oc_reg[1]);
      end
   end

   // drive pin only with direction set
   always_comb begin
      pins.value     = oc_reg;
      pins.enable[0] = ctrl_reg[dsp_pkg::CTRL_DIRA_BIT] && com_a[1];
      pins.enable[1] = ctrl_reg[dsp_pkg::CTRL_DIRB_BIT] && com_b[1];
   end

   // ------------------------------------------------------------
   // flags and interrupt
   // ------------------------------------------------------------
   always_comb begin
      ev = 4'h0;
      ev[dsp_pkg::ST_OVF] = tick && at_bottom && (pc_mode || pfc_mode);
      ev[dsp_pkg::ST_CMA] = match[0] || (tick && at_top && top_is_a);
      ev[dsp_pkg::ST_CMB] = match[1];
      ev[dsp_pkg::ST_CAP] = tick && at_top && !top_is_a &&
                            (wgm == dsp_pkg::WGM_PC_C || wgm == dsp_pkg::WGM_PFC_C);
   end

   // a new event wins over a write-one clear in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         status_reg <= 4'h0;
      end else if (req.wr && req.addr == dsp_pkg::ADDR_STATUS) begin
         status_reg <= (status_reg & ~req.wdata[dsp_pkg::ST_W-1:0]) | ev;
      end else begin
         status_reg <= status_reg | ev;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_reg  <= 10'h000;
         mask_reg  <= 4'h0;
         presc_reg <= dsp_pkg::RESET_VAL;
      end else if (req.wr) begin
         if (req.addr == dsp_pkg::ADDR_CTRL) begin
            ctrl_reg <= req.wdata[9:0];
         end
         if (req.addr == dsp_pkg::ADDR_MASK) begin
            mask_reg <= req.wdata[dsp_pkg::ST_W-1:0];
         end
         if (req.addr == dsp_pkg::ADDR_PRESC) begin
            presc_reg <= req.wdata;
         end
      end
   end

   assign irq = |(status_reg & mask_reg);

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata <= dsp_pkg::RESET_VAL;
      end else if (req.rd) begin
         case (req.addr)
            dsp_pkg::ADDR_CTRL:   rdata <= {6'h00, ctrl_reg};
            dsp_pkg::ADDR_CMP_A:  rdata <= buf_a_reg;
            dsp_pkg::ADDR_CMP_B:  rdata <= buf_b_reg;
            dsp_pkg::ADDR_CAP:    rdata <= cap_reg;
            dsp_pkg::ADDR_CNT:    rdata <= cnt_reg;
            dsp_pkg::ADDR_STATUS: rdata <= {12'h000, status_reg};
            dsp_pkg::ADDR_MASK:   rdata <= {12'h000, mask_reg};
            dsp_pkg::ADDR_PRESC:  rdata <= presc_reg;
            default:              rdata <= dsp_pkg::RESET_VAL;
         endcase
      end else begin
         rdata <= dsp_pkg::RESET_VAL;
      end
   end
endmodule
`default_nettype wire

// file: dv/dsp_timer_sva.sv
// checker: port properties of the dual-slope pwm timer
`timescale 1ns/1ps
`default_nettype none
module dsp_timer_sva (
   input wire logic               clock,
   input wire logic               rst,
   input wire dsp_pkg::dsp_req_s  req,
   input wire logic [15:0]        rdata,
   input wire dsp_pkg::dsp_pins_s pins,
   input wire logic               irq
);
   logic [15:0] ctl_reg;
   logic [15:0] msk_reg;
   logic [15:0] cma_reg;
   logic [10:0] quiet_reg;
   wire logic   rdc = req.rd && req.addr == dsp_pkg::ADDR_CNT;
   // 2047 quiet cycles outlast two periods, so every buffer is live
   wire logic   setl = &quiet_reg && ctl_reg[3:0] == dsp_pkg::WGM_PC8;
   always_ff @(posedge clock) begin
      if (rst) begin
         ctl_reg   <= 16'h0000;
         msk_reg   <= 16'h0000;
         cma_reg   <= 16'h0000;
         quiet_reg <= 11'h000;
      end else begin
         if (req.wr && req.addr == dsp_pkg::ADDR_CTRL) ctl_reg <= req.wdata;
         if (req.wr && req.addr == dsp_pkg::ADDR_MASK) msk_reg <= req.wdata;
         if (req.wr && req.addr == dsp_pkg::ADDR_CMP_A) cma_reg <= req.wdata;
         quiet_reg <= req.wr ? 11'h000 : quiet_reg + {10'h000, ~&quiet_reg};
      end
   end
   default clocking dck @(posedge clock);
   endclocking
   default disable iff (rst);
   property p_rd_idle;
      !req.rd |=> rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero without a read");
   property p_rst;
      $fell(rst) |-> pins == 4'h0 && !irq && rdata == 16'h0000;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not quiet after reset");
   property p_pin_en;
      pins.enable == {ctl_reg[9] & ctl_reg[7], ctl_reg[8] & ctl_reg[5]};
   endproperty
   a_pin_en: assert property (p_pin_en) else $error("pin enable wrong");
   property p_cmp_mask;
      (req.wr && req.addr == dsp_pkg::ADDR_CMP_A && ctl_reg[3:0] == dsp_pkg::WGM_PC8)
         ##1 (req.rd && req.addr == dsp_pkg::ADDR_CMP_A) |=> rdata[15:8] == 8'h00;
   endproperty
   a_cmp_mask: assert property (p_cmp_mask) else $error("compare not masked");
   property p_irq_off;
      msk_reg == 16'h0000 && $stable(msk_reg) |-> !irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq with empty mask");
   property p_ext;
      setl && ctl_reg[5] && (cma_reg == dsp_pkg::BOTTOM || cma_reg == dsp_pkg::TOP_8)
         |-> pins.value[0] == ((cma_reg == dsp_pkg::TOP_8) ^ ctl_reg[4]);
   endproperty
   a_ext: assert property (p_ext) else $error("extreme compare level wrong");
   property p_cnt_top;
      setl && rdc |=> rdata <= dsp_pkg::TOP_8;
   endproperty
   a_cnt_top: assert property (p_cnt_top) else $error("counter above top");
   property p_step;
      setl && rdc ##1 rdc |=> rdata - $past(rdata) == 16'h1 || $past(rdata) - rdata == 16'h1;
   endproperty
   a_step: assert property (p_step) else $error("counter step not one");
   c_setl: cover property (setl && rdc);
   c_irq: cover property ($rose(irq));
   c_pin: cover property ($fell(pins.value[0]));
endmodule
bind dsp_timer dsp_timer_sva u_sva (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
   .pins(pins), .irq(irq));
`default_nettype wire

// file: dv/dsp_load.sv
// partner: load on the compare pins, counting high cycles of channel a
`timescale 1ns/1ps
`default_nettype none
module dsp_load (
   input  wire logic               clock,
   input  wire logic               clr,
   input  wire dsp_pkg::dsp_pins_s pins,
   output logic [1:0]              level,
   output logic [15:0]             hi_a
);
   assign level = pins.enable & pins.value;
   always_ff @(posedge clock) begin
      hi_a <= clr ? 16'h0000 : hi_a + {15'h0000, level[0]};
   end
endmodule
`default_nettype wire

// file: dv/dsp_timer_test.sv
// testbench: directed scenarios for the dual-slope pwm timer
`timescale 1ns/1ps
`default_nettype none
module dsp_timer_test;
   logic               clock;
   logic               rst;
   logic               clr;
   dsp_pkg::dsp_req_s  req;
   logic [15:0]        rdata;
   dsp_pkg::dsp_pins_s pins;
   logic               irq;
   logic [1:0]         level;
   logic [15:0]        hi_a;
   logic [15:0]        d;
   int                 n_fail;
   int                 n_checks;
   dsp_timer dut (.clock(clock), .rst(rst), .req(req), .rdata(rdata), .pins(pins), .irq(irq));
   dsp_load u_load (.clock(clock), .clr(clr), .pins(pins), .level(level), .hi_a(hi_a));
   always #2 clock = ~clock;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clock);
      req <= '{a, v, 1'b1, 1'b0};
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clock);
      req <= '0;
      #1 d = rdata;
   endtask
   task automatic hold(input int n);
      @(posedge clock);
      req <= '0;
      repeat (n) @(posedge clock);
      #1;
   endtask
   // strobe held on the counter: steps of one, nothing above top
   task automatic burst(input int n, input logic [15:0] t, input logic [15:0] x, input int nx);
      logic [15:0] p;
      int          k;
      k = 0;
      @(posedge clock);
      req <= '{dsp_pkg::ADDR_CNT, 16'h0000, 1'b0, 1'b1};
      @(posedge clock);
      #1 p = rdata;
      for (int i = 1; i < n; i++) begin
         @(posedge clock);
         #1 chk({15'h0, rdata <= t && (rdata - p == 16'h1 || p - rdata == 16'h1)}, 16'h1);
         k += (rdata == x) ? 1 : 0;
         p = rdata;
      end
      chk(16'(k), 16'(nx));
      @(posedge clock);
      req <= '0;
   endtask
   // one top turn, then one bottom turn, flags checked after each
   task automatic s_mode(input logic [3:0] m, input logic [15:0] t);
      logic ta;
      ta = m == 4'h9 || m == 4'hb;
      // top only changes with the counter stopped
      wr(dsp_pkg::ADDR_CTRL, 16'h0000);
      wr(dsp_pkg::ADDR_CMP_A, ta ? 16'h0020 : 16'h0010);
      wr(dsp_pkg::ADDR_CMP_B, 16'h0010);
      wr(dsp_pkg::ADDR_CAP, 16'h0020);
      wr(dsp_pkg::ADDR_CNT, 16'h0000);
      wr(dsp_pkg::ADDR_CTRL, {12'h000, m});
      rd(dsp_pkg::ADDR_STATUS);
      wr(dsp_pkg::ADDR_STATUS, 16'h000f);
      burst(t + 4, t, t, 1);
      rd(dsp_pkg::ADDR_STATUS);
      chk(d, (m == 4'h8 || m == 4'ha) ? 16'h000e : 16'h0006);
      wr(dsp_pkg::ADDR_STATUS, 16'h000f);
      burst(t, t, 16'h0000, 1);
      rd(dsp_pkg::ADDR_STATUS);
      chk(d, ta ? 16'h0005 : 16'h0007);
      wr(dsp_pkg::ADDR_CMP_A, 16'hffff);
      rd(dsp_pkg::ADDR_CMP_A);
      chk(d, m < 4'h4 ? t : 16'hffff);
   endtask
   // high cycles of channel a over one 510-cycle period at top 0xff
   task automatic s_pwm(input logic [15:0] c, input logic [15:0] v, input logic [15:0] e);
      wr(dsp_pkg::ADDR_CTRL, c);
      wr(dsp_pkg::ADDR_CNT, 16'h0000);
      wr(dsp_pkg::ADDR_CMP_A, v);
      hold(2100);
      burst(8, dsp_pkg::TOP_8, 16'hffff, 0);
      clr <= 1'b1;
      @(posedge clock);
      clr <= 1'b0;
      repeat (510) @(posedge clock);
      #1 chk(hi_a, e);
   endtask
   task automatic s_irq;
      wr(dsp_pkg::ADDR_STATUS, 16'h000f);
      wr(dsp_pkg::ADDR_MASK, 16'h0001);
      hold(520);
      chk({15'h0, irq}, 16'h0001);
      wr(dsp_pkg::ADDR_MASK, 16'h0000);
      hold(2);
      chk({15'h0, irq}, 16'h0000);
      wr(dsp_pkg::ADDR_CTRL, 16'h0000);
      wr(dsp_pkg::ADDR_STATUS, 16'h000f);
      wr(dsp_pkg::ADDR_MASK, 16'h000f);
      wr(4'hf, 16'hffff);
      rd(4'hf);
      chk(d, 16'h0000);
      rd(dsp_pkg::ADDR_STATUS);
      chk(d, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
   endtask
   // compare b above a register top never matches; prescaler halves the tick
   task automatic s_above;
      wr(dsp_pkg::ADDR_CTRL, 16'h0000);
      wr(dsp_pkg::ADDR_PRESC, 16'h0001);
      // capture top kept fixed while running
      wr(dsp_pkg::ADDR_CAP, 16'h0020);
      wr(dsp_pkg::ADDR_CMP_A, 16'h0010);
      wr(dsp_pkg::ADDR_CMP_B, 16'h0030);
      wr(dsp_pkg::ADDR_CNT, 16'h0000);
      wr(dsp_pkg::ADDR_CTRL, 16'h000a);
      wr(dsp_pkg::ADDR_STATUS, 16'h000f);
      hold(260);
      rd(dsp_pkg::ADDR_STATUS);
      chk(d, 16'h000b);
      rd(dsp_pkg::ADDR_PRESC);
      chk(d, 16'h0001);
   endtask
   task automatic final_report;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      final_report();
   end
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      clr = 1'b0;
      req = '0;
      n_fail = 0;
      n_checks = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rd(dsp_pkg::ADDR_CNT);
      chk(d, 16'h0000);
      rd(dsp_pkg::ADDR_CMP_A);
      chk(d, 16'h0000);
      chk({12'h000, pins}, 16'h0000);
      s_mode(4'h1, 16'h00ff);
      s_mode(4'h2, 16'h01ff);
      s_mode(4'h3, 16'h03ff);
      s_mode(4'h8, 16'h0020);
      s_mode(4'h9, 16'h0020);
      s_mode(4'ha, 16'h0020);
      s_mode(4'hb, 16'h0020);
      s_pwm(16'h0121, 16'h0040, 16'd128);
      s_pwm(16'h0131, 16'h0040, 16'd382);
      s_pwm(16'h0021, 16'h0040, 16'd0);
      s_pwm(16'h0121, 16'h0000, 16'd0);
      s_pwm(16'h0121, 16'h00ff, 16'd510);
      s_pwm(16'h0131, 16'h0000, 16'd510);
      s_irq();
      s_above();
      final_report();
   end
endmodule
`default_nettype wire
